// file: array_if.sv
// Purpose: word port between the sequencer and its cell array
// Assumes: one access per cycle, read data combinational
// Notes: the sequencer drives the address, passing the host address through while idle

`timescale 1ns/1ps

interface array_if;
  import erase_pkg::*;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output wr, output addr, output wdata, input rdata);
  modport mem (input wr, input addr, input wdata, output rdata);
endinterface : array_if

// file: cell_array.sv
// Purpose: storage cells of all blocks
// Assumes: contents are not touched by reset, like real cells
// Notes: read is asynchronous so the verify pass takes one word per cycle

`timescale 1ns/1ps

module cell_array (
  input wire logic clk_i, // system clock
  array_if.mem port_io    // word access port
);
  import erase_pkg::*;

  logic [7:0] mem_q [NUM_WORDS];

  always_ff @(posedge clk_i) begin
    if (port_io.wr) begin
      mem_q[port_io.addr] <= port_io.wdata;
    end
  end

  assign port_io.rdata = mem_q[port_io.addr];

endmodule : cell_array

// file: erase_pkg.sv
// Purpose: shared constants and types for the block-erase sequencer
// Assumes: byte-wide command/status bus, small embedded array model
// Notes: the array geometry is kept small so that the whole array fits in flops

package erase_pkg;

  // array geometry
  localparam int BLK_W = 2;
  localparam int WORD_W = 3;
  localparam int ADDR_W = BLK_W + WORD_W;
  localparam int NUM_WORDS = 1 << ADDR_W;
  localparam logic [WORD_W-1:0] WORD_LAST = {WORD_W{1'b1}};

  // command codes
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;

  // data values
  localparam logic [7:0] ERASED_WORD = 8'hff;
  localparam logic [7:0] PRECOND_WORD = 8'h00;

  // status bit positions
  localparam int SR_READY = 7;
  localparam int SR_ERASE_SUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_SUPPLY_LOW = 3;
  localparam int SR_PROG_SUSP = 2;
  localparam int SR_PROTECT = 1;

  // erase pulse: least time, rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERASE_PULSE_NS = 80;
  localparam int ERASE_PULSE_CYC = (ERASE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_W = 4;
  localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(ERASE_PULSE_CYC - 1);

  typedef enum logic [2:0] {
    W_READY,
    W_PRECOND,
    W_PULSE,
    W_ERASE,
    W_VERIFY,
    W_SUSP
  } wsm_type;

endpackage : erase_pkg

// file: erase_sequencer.sv
// Purpose: command decode, erase state machine and status byte of the device
// Assumes: we_i and rd_i are one-cycle strobes synchronous to clk_i
// Notes: read data appears one cycle after rd_i and holds until the next read

`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - one block erased, only after two writes
// - setup code 20h, confirm code d0h
// - erased words all hold ff
// - machine preconditions, erases, verifies unaided
// - after sequence, reads return status byte
// - status mode kept until next command
// - bit 7 ready high, busy low
// - bit 5 flags failed erase
// - bits 4, 3, 1 give error cause
// - bits 5 and 4 mean bad sequence
// - suspend halts, sets bits 7 and 6
// - bit 6 held until resume command
// - error bits cleared only by 50h
module erase_sequencer (
  input wire logic clk_i, // system clock
  input wire logic rst_b_i, // synchronous reset, active low
  input wire logic we_i, // host write strobe
  input wire logic rd_i, // host read strobe
  input wire logic [erase_pkg::ADDR_W-1:0] addr_i, // host address
  input wire logic [7:0] wdata_i, // host write data
  input wire logic supply_ok_i, // programming supply good
  input wire logic wp_unlock_i, // write-protect at unlock level
  input wire logic [(1 << erase_pkg::BLK_W)-1:0] lock_i, // per-block lock
  output logic [7:0] rdata_o // host read data
);
  import erase_pkg::*;

  typedef struct packed {
    wsm_type write_state_machine;
    wsm_type resume;
    logic status_mode;
    logic setup_pend;
    logic [BLK_W-1:0] blk;
    logic [WORD_W-1:0] word;
    logic [PULSE_W-1:0] pulse;
    logic erase_susp;
    logic erase_err;
    logic prog_err;
    logic supply_low;
    logic protect;
    logic [7:0] rdata;
  } state_type;

  state_type st_q;
  state_type st_d;
  array_if arr ();
  logic arr_wr;
  logic [ADDR_W-1:0] arr_addr;
  logic [7:0] arr_wdata;
  logic busy;
  logic [BLK_W-1:0] tgt_blk;

  ////////////////////////////////////////////////////////////////////////////////

  // program suspend does not exist in this block, so its flag reads zero
  function automatic logic [7:0] status_byte(input state_type s);
    logic [7:0] b;
    b = 8'h00;
    b[SR_READY] = (s.write_state_machine == W_READY) || (s.write_state_machine == W_SUSP);
    b[SR_ERASE_SUSP] = s.erase_susp;
    b[SR_ERASE_ERR] = s.erase_err;
    b[SR_PROG_ERR] = s.prog_err;
    b[SR_SUPPLY_LOW] = s.supply_low;
    b[SR_PROG_SUSP] = 1'b0;
    b[SR_PROTECT] = s.protect;
    return b;
  endfunction : status_byte

  function automatic logic is_busy(input wsm_type w);
    return (w != W_READY) && (w != W_SUSP);
  endfunction : is_busy

  assign busy = is_busy(st_q.write_state_machine);
  assign tgt_blk = addr_i[ADDR_W-1:WORD_W];
  assign arr.wr = arr_wr;
  assign arr.addr = arr_addr;
  assign arr.wdata = arr_wdata;

  cell_array u_cells (
    .clk_i(clk_i),
    .port_io(arr.mem)
  );

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_d = st_q;
    arr_wr = 1'b0;
    arr_wdata = PRECOND_WORD;
    // the host owns the array address only while the machine is idle or suspended
    arr_addr = busy ? {st_q.blk, st_q.word} : addr_i;

    unique case (st_q.write_state_machine)
      W_READY, W_SUSP: begin
      end
      W_PRECOND: begin
        arr_wr = 1'b1;
        st_d.word = st_q.word + 1'b1;
        if (st_q.word == WORD_LAST) begin
          st_d.write_state_machine = W_PULSE;
          st_d.pulse = '0;
        end
      end
      W_PULSE: begin
        st_d.pulse = st_q.pulse + 1'b1;
        if (st_q.pulse == PULSE_LAST) begin
          st_d.write_state_machine = W_ERASE;
        end
      end
      W_ERASE: begin
        arr_wr = 1'b1;
        arr_wdata = ERASED_WORD;
        st_d.word = st_q.word + 1'b1;
        if (st_q.word == WORD_LAST) begin
          st_d.write_state_machine = W_VERIFY;
        end
      end
      W_VERIFY: begin
        st_d.word = st_q.word + 1'b1;
        if (arr.rdata != ERASED_WORD) begin
          st_d.erase_err = 1'b1;
          st_d.write_state_machine = W_READY;
        end else if (st_q.word == WORD_LAST) begin
          st_d.write_state_machine = W_READY;
        end
      end
    endcase

    if (busy && !supply_ok_i) begin
      arr_wr = 1'b0;
      st_d.supply_low = 1'b1;
      st_d.erase_err = 1'b1;
      st_d.write_state_machine = W_READY;
    end

    if (we_i) begin
      if (busy) begin
        if (wdata_i == CMD_SUSPEND && st_d.write_state_machine != W_READY) begin
          st_d.resume = st_d.write_state_machine;
          st_d.write_state_machine = W_SUSP;
          st_d.erase_susp = 1'b1;
        end
      end else if (st_q.setup_pend) begin
        st_d.setup_pend = 1'b0;
        st_d.status_mode = 1'b1;
        if (wdata_i == CMD_CONFIRM) begin
          st_d.blk = tgt_blk;
          st_d.word = '0;
          if (!supply_ok_i) begin
            st_d.supply_low = 1'b1;
            st_d.erase_err = 1'b1;
          end else if (lock_i[tgt_blk] && !wp_unlock_i) begin
            st_d.protect = 1'b1;
            st_d.erase_err = 1'b1;
          end else begin
            st_d.write_state_machine = W_PRECOND;
          end
        end else begin
          st_d.erase_err = 1'b1;
          st_d.prog_err = 1'b1;
        end
      end else begin
        case (wdata_i)
          CMD_ERASE_SETUP: begin
            if (st_q.write_state_machine == W_READY) begin
              st_d.setup_pend = 1'b1;
            end
          end
          CMD_CLEAR_STATUS: begin
            st_d.erase_err = 1'b0;
            st_d.prog_err = 1'b0;
            st_d.supply_low = 1'b0;
            st_d.protect = 1'b0;
            st_d.status_mode = 1'b0;
          end
          CMD_READ_STATUS: begin
            st_d.status_mode = 1'b1;
          end
          CMD_READ_ARRAY: begin
            st_d.status_mode = 1'b0;
          end
          CMD_CONFIRM: begin
            if (st_q.write_state_machine == W_SUSP) begin
              st_d.write_state_machine = st_q.resume;
              st_d.erase_susp = 1'b0;
              st_d.status_mode = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // status bits below 7 meaningless while busy
    if (rd_i) begin
      st_d.rdata = (st_q.status_mode || busy) ? status_byte(st_q) : arr.rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  read_status_a: assert property (
    rd_i && st_q.status_mode |=> rdata_o == status_byte($past(st_q)))
    else $error("status read returned wrong byte");

  ready_bit_a: assert property (
    rd_i && busy |=> rdata_o[SR_READY] == 1'b0)
    else $error("ready bit high while busy");

  erase_start_a: assert property (
    st_q.write_state_machine == W_READY && st_d.write_state_machine == W_PRECOND |-> st_q.setup_pend && we_i
      && wdata_i == CMD_CONFIRM)
    else $error("erase started without full sequence");

  erase_value_a: assert property (
    st_q.write_state_machine == W_ERASE && supply_ok_i |-> arr_wr && arr_wdata == ERASED_WORD)
    else $error("erase phase wrote non-erased value");

  mode_hold_a: assert property (
    st_q.status_mode && !we_i |=> st_q.status_mode)
    else $error("status mode dropped without a command");

  bad_sequence_a: assert property (
    !busy && st_q.setup_pend && we_i && wdata_i != CMD_CONFIRM
      |=> st_q.erase_err && st_q.prog_err && st_q.status_mode)
    else $error("bad sequence not flagged");

  suspend_flags_a: assert property (
    busy && supply_ok_i && st_q.write_state_machine != W_VERIFY && we_i && wdata_i == CMD_SUSPEND
      |=> st_q.write_state_machine == W_SUSP && !is_busy(st_q.write_state_machine) && st_q.erase_susp)
    else $error("suspend did not halt with flags");

  suspend_hold_a: assert property (
    st_q.erase_susp && !(we_i && wdata_i == CMD_CONFIRM) |=> st_q.erase_susp)
    else $error("suspend flag dropped before resume");

  error_sticky_a: assert property (
    st_q.erase_err && !(we_i && wdata_i == CMD_CLEAR_STATUS) |=> st_q.erase_err)
    else $error("error bit lost without clear");

  supply_abort_a: assert property (
    busy && !supply_ok_i |=> st_q.supply_low && st_q.write_state_machine == W_READY)
    else $error("supply loss did not abort");

  protect_abort_a: assert property (
    !busy && st_q.setup_pend && we_i && wdata_i == CMD_CONFIRM && supply_ok_i
      && lock_i[tgt_blk] && !wp_unlock_i |=> st_q.protect && st_q.write_state_machine == W_READY)
    else $error("locked block erase not refused");

  supply_refuse_a: assert property (
    !busy && st_q.setup_pend && we_i && wdata_i == CMD_CONFIRM && !supply_ok_i
      |=> st_q.supply_low && st_q.erase_err && st_q.write_state_machine == W_READY)
    else $error("low supply confirm not refused");

  resume_clear_a: assert property (
    st_q.write_state_machine == W_SUSP && we_i && wdata_i == CMD_CONFIRM
      |=> !st_q.erase_susp && busy)
    else $error("resume did not restart erase");

  // a suspend inside the pass would stretch it and a supply drop would end it, so both are excluded
  erase_length_a: assert property (
    st_q.write_state_machine == W_READY ##1 st_q.write_state_machine == W_PRECOND ##0 (supply_ok_i && !we_i) [*8]
      |=> st_q.write_state_machine == W_PULSE)
    else $error("precondition pass length wrong");

endmodule : erase_sequencer

// file: host_model.sv
// Purpose: host bus master issuing command writes and status or array reads
// Assumes: strobes change at the falling edge and last one cycle
// Notes: idle address and data are inverted after use so stale values never pass

`timescale 1ns/1ps

module host_model (
  input wire logic clk_i, // system clock
  input wire logic [7:0] rdata_i, // device read data
  output logic we_o, // write strobe
  output logic rd_o, // read strobe
  output logic [erase_pkg::ADDR_W-1:0] addr_o, // bus address
  output logic [7:0] wdata_o // command code
);
  import erase_pkg::*;

  initial begin
    we_o = 1'b0;
    rd_o = 1'b0;
    addr_o = '0;
    wdata_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one command per strobe, in caller's order
  task automatic write_cmd(input logic [7:0] code, input logic [ADDR_W-1:0] adr);
    @(negedge clk_i);
    we_o = 1'b1;
    wdata_o = code;
    addr_o = adr;
    @(negedge clk_i);
    we_o = 1'b0;
    wdata_o = ~code;
    addr_o = ~adr;
  endtask : write_cmd

  // extra falling edge: the answer has landed and holds until the next read
  task automatic read_reg(input logic [ADDR_W-1:0] adr, output logic [7:0] val);
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = adr;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~adr;
    @(negedge clk_i);
    val = rdata_i;
  endtask : read_reg
endmodule : host_model

// file: tb.sv
// Purpose: self-checking bench for the block-erase sequencer
// Assumes: host_model drives the bus; supply, lock and protect set here
// Notes: status checked in full only once the ready bit is high

`timescale 1ns/1ps

module tb;
  import erase_pkg::*;

  logic clk, rst_b, we, rd, supply_ok, wp_unlock;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata, sr;
  logic [(1 << BLK_W)-1:0] lock;
  logic [7:0] err_exp [3] = '{8'ha8, 8'ha2, 8'hb0};
  int failures = 0;
  int tests_run = 0;

  erase_sequencer DUT (.clk_i(clk), .rst_b_i(rst_b), .we_i(we), .rd_i(rd), .addr_i(addr),
    .wdata_i(wdata), .supply_ok_i(supply_ok), .wp_unlock_i(wp_unlock), .lock_i(lock),
    .rdata_o(rdata));
  host_model host (.clk_i(clk), .rdata_i(rdata), .we_o(we), .rd_o(rd), .addr_o(addr),
    .wdata_o(wdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // setup at any address, confirm inside the block
  task automatic erase(input int blk);
    host.write_cmd(CMD_ERASE_SETUP, '0);
    host.write_cmd(CMD_CONFIRM, ADDR_W'(blk << WORD_W));
  endtask : erase

  // bounded wait for the ready bit
  task automatic poll(output logic [7:0] val);
    for (int i = 0; i < 40; i++) begin
      host.read_reg('0, val);
      if (val[SR_READY] === 1'b1) return;
    end
    failures++;
    wrap_up();
  endtask : poll

  // clear after an error, then back to status mode
  task automatic clear_status;
    host.write_cmd(CMD_CLEAR_STATUS, '0);
    host.write_cmd(CMD_READ_STATUS, '0);
  endtask : clear_status

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    supply_ok = 1'b1;
    wp_unlock = 1'b0;
    lock = '0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    host.write_cmd(CMD_READ_STATUS, '0);
    host.read_reg('0, sr);
    check("idle status", sr, 8'h80);
    erase(1);
    host.read_reg('0, sr);
    check("busy bit", {7'h00, sr[SR_READY]}, 8'h00);
    poll(sr);
    check("erase done", sr, 8'h80);
    host.read_reg(ADDR_W'(8), sr);
    check("still status", sr, 8'h80);
    host.write_cmd(CMD_READ_ARRAY, '0);
    for (int w = 0; w < 8; w++) begin
      host.read_reg(ADDR_W'(8 + w), sr);
      check("erased word", sr, ERASED_WORD);
    end
    // supply low, locked block, bad second write
    for (int k = 0; k < 3; k++) begin
      supply_ok = (k != 0);
      lock = (k == 1) ? 4'h4 : 4'h0;
      host.write_cmd(CMD_ERASE_SETUP, '0);
      host.write_cmd(k == 2 ? CMD_READ_STATUS : CMD_CONFIRM, ADDR_W'(k * 8 + 8));
      poll(sr);
      check("error status", sr, err_exp[k]);
      host.write_cmd(CMD_READ_STATUS, '0);
      host.read_reg('0, sr);
      check("error held", sr, err_exp[k]);
      clear_status();
      host.read_reg('0, sr);
      check("cleared", sr, 8'h80);
    end
    // unlock level lets a locked block erase
    supply_ok = 1'b1;
    wp_unlock = 1'b1;
    lock = 4'h4;
    erase(2);
    poll(sr);
    check("unlocked erase", sr, 8'h80);
    erase(3);
    host.write_cmd(CMD_SUSPEND, '0);
    host.read_reg('0, sr);
    check("suspended", sr, 8'hc0);
    repeat (40) @(negedge clk);
    host.read_reg('0, sr);
    check("suspend held", sr, 8'hc0);
    host.write_cmd(CMD_CONFIRM, '0);
    host.read_reg('0, sr);
    check("resumed", {6'h00, sr[7:6]}, 8'h00);
    poll(sr);
    check("resumed done", sr, 8'h80);
    host.write_cmd(CMD_READ_ARRAY, '0);
    host.read_reg({2'h3, WORD_LAST}, sr);
    check("last word", sr, ERASED_WORD);
    erase(0);
    supply_ok = 1'b0;
    poll(sr);
    check("supply drop", sr, 8'ha8);
    supply_ok = 1'b1;
    clear_status();
    host.read_reg('0, sr);
    check("drop cleared", sr, 8'h80);
    wrap_up();
  end
endmodule : tb
